// ### mbxc_flash_model.sv
// Behavioural external flash answering cache fills and raw requests
`timescale 1ns/1ps
module mbxc_flash_model (
   input  wire logic                  ref_clk,
   input  wire mbxc_pkg::mbxc_flash_s flash_out,
   input  wire logic                  slow,
   output      logic                  flash_ack,
   output      logic [31:0]           flash_rdata
);
   logic [31:0] mem [logic [22:0]];
   logic [1:0]  wait_r;
   initial begin
      flash_ack = 1'b0;
      flash_rdata = 32'h0;
      wait_r = 2'h0;
   end
   // One answer per request beat; no ack in the ack cycle itself
   always @(posedge ref_clk) begin
      flash_ack <= 1'b0;
      flash_rdata <= ~flash_rdata; // Idle bus never shows a stale word
      if (flash_out.req && !flash_ack) begin
         if (slow && wait_r != 2'h2) begin
            wait_r <= wait_r + 2'h1;
         end else begin
            wait_r <= 2'h0;
            flash_ack <= 1'b1;
            case (flash_out.cmd)
               mbxc_pkg::FL_WRITE: mem[flash_out.addr] = flash_out.wdata;
               // Word-sized erase only, a simplification
               mbxc_pkg::FL_ERASE: mem[flash_out.addr] = 32'hFFFFFFFF;
               default: flash_rdata <= mem.exists(flash_out.addr) ?
                  mem[flash_out.addr] : {flash_out.addr, 9'h0A5};
            endcase
         end
      end
   end
endmodule // mbxc_flash_model

// ### mbxc_memsys.sv
// Address map, configurable RAM banks and execute-in-place cache
`timescale 1ns/1ps
module mbxc_memsys (
   input  wire  logic                     ref_clk,
   input  wire  logic                     rst,
   input  wire  logic                     boot_source_strap,
   input  wire  logic                     fw_cache_en,
   input  wire  logic [6:0][1:0]          bank_state,
   output       logic                     cache_on,
   input  wire  logic                     ireq,
   input  wire  logic [23:0]              iaddr,
   output       logic                     iready,
   output       logic                     ivalid,
   output       logic                     ierr,
   output       logic [31:0]              irdata,
   output       logic [15:0]              rom_addr,
   input  wire  logic [31:0]              rom_rdata,
   input  wire  logic                     dreq,
   input  wire  logic                     dwe,
   input  wire  logic [3:0]               dbe,
   input  wire  logic [23:0]              daddr,
   input  wire  logic [31:0]              dwdata,
   output       logic                     dready,
   output       logic                     dvalid,
   output       logic                     derr,
   output       logic [31:0]              drdata,
   output       logic                     per_req,
   output       logic                     per_we,
   output       logic [19:0]              per_addr,
   output       logic [31:0]              per_wdata,
   input  wire  logic                     per_ack,
   input  wire  logic [31:0]              per_rdata,
   input  wire  mbxc_pkg::mbxc_flash_s    raw_flash,
   output       logic                     raw_grant,
   output       logic                     raw_done,
   output       logic [31:0]              raw_rdata,
   output       mbxc_pkg::mbxc_flash_s    flash_out,
   input  wire  logic                     flash_ack,
   input  wire  logic [31:0]              flash_rdata
);
   typedef enum {I_IDLE, I_FILL} mbxc_ist_e;
   typedef enum {D_IDLE, D_PER} mbxc_dst_e;

   logic [31:0]          mem [0:mbxc_pkg::MEM_WORDS-1];
   logic [8:0]           tag_r   [0:1][0:mbxc_pkg::SETS-1];
   logic                 valid_r [0:1][0:mbxc_pkg::SETS-1];
   logic                 lru_r   [0:mbxc_pkg::SETS-1];
   mbxc_ist_e            ist_r;
   mbxc_dst_e            dst_r;
   logic                 boot_flash_r;
   logic                 strap_done_r;
   logic                 ivalid_r;
   logic                 ierr_r;
   logic                 irom_r;
   logic [31:0]          ird_r;
   logic                 dvalid_r;
   logic                 derr_r;
   logic [31:0]          drd_r;
   logic [19:0]          per_addr_r;
   logic                 per_we_r;
   logic [31:0]          per_wdata_r;
   logic [7:0]           fset_r;
   logic [8:0]           ftag_r;
   logic                 fway_r;
   logic [3:0]           fword_r;
   logic [3:0]           cnt_r;
   logic [19:0]          ioff;
   logic [22:0]          ifo;
   logic [7:0]           iset;
   logic [8:0]           itag;
   logic                 hit0;
   logic                 hit1;
   logic                 in_flash;
   logic                 raw_active;
   logic                 fill_beat;
   logic                 fill_last;
   logic [16:0]          ibank;
   logic [16:0]          dbank;
   logic [19:0]          doff;
   logic                 dtake;
   logic                 dram_ok;
   logic [15:0]          dram_ix;
   logic [8:0]           td_ix;

   // Window offset inside a bank range: {ok, word index}
   function automatic logic [16:0] bank_word(
      input logic [19:0]     off,
      input logic [19:0]     base,
      input mbxc_pkg::mbxc_bank_e want,
      input logic [6:0][1:0] st,
      input logic            con
   );
      logic [19:0] rel;
      logic [2:0]  b;
      logic        ok;
      rel = off - base;
      b   = rel[17:15];
      ok  = (off >= base) && (rel[19:18] == 2'b00)
            && (b < 3'(mbxc_pkg::NBANKS))
            && (mbxc_pkg::mbxc_bank_e'(st[b]) == want)
            && !(b == 3'(mbxc_pkg::NBANKS - 1) && con);
      return {ok, mbxc_pkg::WIX_BANK0 + {b, rel[14:2]}};
   endfunction

   // Strap is sampled on the first clock after reset release
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         boot_flash_r <= 1'b0;
         strap_done_r <= 1'b0;
      end else if (!strap_done_r) begin
         boot_flash_r <= ~boot_source_strap;
         strap_done_r <= 1'b1;
      end
   end

   assign cache_on = boot_flash_r | fw_cache_en;

   // Region decode of the fetch address
   assign ioff     = iaddr[19:0];
   assign ifo      = 23'(iaddr - mbxc_pkg::FLASH_BASE);
   assign iset     = ifo[13:6];
   assign itag     = ifo[22:14];
   assign in_flash = (iaddr[23:20] >= mbxc_pkg::REG_FLASH_LO)
                     && (iaddr[23:20] <= mbxc_pkg::REG_FLASH_HI);
   assign hit0     = valid_r[0][iset] && (tag_r[0][iset] == itag);
   assign hit1     = valid_r[1][iset] && (tag_r[1][iset] == itag);
   assign ibank    = bank_word(ioff, mbxc_pkg::IBANK_BASE,
                               mbxc_pkg::BANK_INSTR, bank_state, cache_on);
   assign rom_addr = ioff[17:2];

   // Raw flash traffic excludes fills; the cache owns the flash while on
   assign raw_active = raw_flash.req && !cache_on;
   assign raw_grant  = raw_active && (ist_r == I_IDLE);
   assign raw_done   = raw_grant && flash_ack;
   assign raw_rdata  = flash_rdata;
   assign fill_beat  = (ist_r == I_FILL) && flash_ack;
   assign fill_last  = fill_beat && (cnt_r == mbxc_pkg::LAST_BEAT);
   assign iready     = (ist_r == I_IDLE) && !raw_active;

   always_comb begin
      flash_out = '0;
      if (ist_r == I_FILL) begin
         flash_out.req  = 1'b1;
         flash_out.cmd  = mbxc_pkg::FL_READ;
         flash_out.addr = {ftag_r, fset_r, cnt_r, 2'b00};
      end else if (raw_grant) begin
         flash_out = raw_flash;
      end
   end

   // Fetch side: ROM, fixed RAM, instruction banks and cached flash
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ist_r    <= I_IDLE;
         ivalid_r <= 1'b0;
         ierr_r   <= 1'b0;
         irom_r   <= 1'b0;
         ird_r    <= 32'h00000000;
         fset_r   <= 8'h00;
         ftag_r   <= 9'h000;
         fway_r   <= 1'b0;
         fword_r  <= 4'h0;
         cnt_r    <= 4'h0;
      end else begin
         ivalid_r <= 1'b0;
         ierr_r   <= 1'b0;
         case (ist_r)
            I_IDLE: begin
               if (ireq && iready) begin
                  irom_r <= 1'b0;
                  if (iaddr[23:20] == mbxc_pkg::REG_INSTR) begin
                     if (ioff < mbxc_pkg::ROM_BYTES) begin
                        irom_r   <= 1'b1;
                        ivalid_r <= 1'b1;
                     end else if (ioff < mbxc_pkg::IBANK_BASE) begin
                        ird_r    <= mem[mbxc_pkg::WIX_FIX_I +
                                        {4'h0, ioff[13:2]}];
                        ivalid_r <= 1'b1;
                     end else if (ibank[16]) begin
                        ird_r    <= mem[ibank[15:0]];
                        ivalid_r <= 1'b1;
                     end else begin
                        ierr_r   <= 1'b1;
                     end
                  end else if (in_flash && cache_on) begin
                     if (hit0 || hit1) begin
                        ird_r    <= mem[mbxc_pkg::WIX_CACHE +
                                        {3'b000, hit1, iset, ifo[5:2]}];
                        ivalid_r <= 1'b1;
                     end else begin
                        ist_r   <= I_FILL;
                        fset_r  <= iset;
                        ftag_r  <= itag;
                        fway_r  <= lru_r[iset];
                        fword_r <= ifo[5:2];
                        cnt_r   <= 4'h0;
                     end
                  end else begin
                     // Window is dark while the cache is off
                     ierr_r <= 1'b1;
                  end
               end
            end
            I_FILL: begin
               if (fill_beat) begin
                  cnt_r <= cnt_r + 4'h1;
                  if (cnt_r == fword_r) begin
                     ird_r <= flash_rdata;
                  end
                  if (fill_last) begin
                     ist_r    <= I_IDLE;
                     ivalid_r <= 1'b1;
                  end
               end
            end
            default: ist_r <= I_IDLE;
         endcase
      end
   end

   assign ivalid = ivalid_r;
   assign ierr   = ierr_r;
   assign irdata = irom_r ? rom_rdata : ird_r;

   // Data side decode
   assign doff    = daddr[19:0];
   assign dtake   = dreq && (dst_r == D_IDLE);
   assign dbank   = bank_word(doff, mbxc_pkg::DBANK_BASE,
                              mbxc_pkg::BANK_DATA, bank_state, cache_on);
   assign dram_ok = (daddr[23:20] == mbxc_pkg::REG_DATA)
                    && ((doff < mbxc_pkg::FIX_BYTES) || dbank[16]);
   assign dram_ix = (doff < mbxc_pkg::FIX_BYTES)
                    ? mbxc_pkg::WIX_FIX_D + {4'h0, doff[13:2]}
                    : dbank[15:0];
   assign td_ix   = daddr[10:2];
   assign dready  = (dst_r == D_IDLE);

   // RAM writes: cache fill beats and data stores
   always_ff @(posedge ref_clk) begin
      if (fill_beat) begin
         mem[mbxc_pkg::WIX_CACHE + {3'b000, fway_r, fset_r, cnt_r}]
            <= flash_rdata;
      end
      if (dtake && dwe && dram_ok) begin
         for (int i = 0; i < 4; i++) begin
            if (dbe[i]) begin
               mem[dram_ix][i*8 +: 8] <= dwdata[i*8 +: 8];
            end
         end
      end
   end

   // Tag store: installed by fills, written by software for invalidation
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         for (int s = 0; s < mbxc_pkg::SETS; s++) begin
            lru_r[s] <= 1'b0;
         end
      end else begin
         if (fill_last) begin
            tag_r[fway_r][fset_r]   <= ftag_r;
            valid_r[fway_r][fset_r] <= 1'b1;
            lru_r[fset_r]           <= ~fway_r;
         end else if (ist_r == I_IDLE && ireq && iready && in_flash
                      && cache_on && (hit0 || hit1)) begin
            lru_r[iset] <= ~hit1;
         end
         if (dtake && dwe && daddr[23:20] == mbxc_pkg::REG_TAGDIR
             && !(fill_last && {fway_r, fset_r} == td_ix)) begin
            tag_r[td_ix[8]][td_ix[7:0]]   <= dwdata[8:0];
            valid_r[td_ix[8]][td_ix[7:0]] <=
               dwdata[mbxc_pkg::TD_VALID_BIT];
         end
      end
   end

   // Data side: coupled RAM, tag window, peripheral region
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         dst_r       <= D_IDLE;
         dvalid_r    <= 1'b0;
         derr_r      <= 1'b0;
         drd_r       <= 32'h00000000;
         per_addr_r  <= 20'h00000;
         per_we_r    <= 1'b0;
         per_wdata_r <= 32'h00000000;
      end else begin
         dvalid_r <= 1'b0;
         derr_r   <= 1'b0;
         case (dst_r)
            D_IDLE: begin
               if (dtake) begin
                  if (dram_ok) begin
                     if (!dwe) begin
                        drd_r <= mem[dram_ix];
                     end
                     dvalid_r <= 1'b1;
                  end else if (daddr[23:20] == mbxc_pkg::REG_TAGDIR) begin
                     drd_r <= {valid_r[td_ix[8]][td_ix[7:0]], 22'h000000,
                               tag_r[td_ix[8]][td_ix[7:0]]};
                     dvalid_r <= 1'b1;
                  end else if (daddr[23:20] == mbxc_pkg::REG_PERIPH) begin
                     dst_r       <= D_PER;
                     per_addr_r  <= doff;
                     per_we_r    <= dwe;
                     per_wdata_r <= dwdata;
                  end else begin
                     // Instruction area and flash are not data-addressable
                     derr_r <= 1'b1;
                  end
               end
            end
            D_PER: begin
               if (per_ack) begin
                  dst_r    <= D_IDLE;
                  drd_r    <= per_rdata;
                  dvalid_r <= 1'b1;
               end
            end
            default: dst_r <= D_IDLE;
         endcase
      end
   end

   assign dvalid    = dvalid_r;
   assign derr      = derr_r;
   assign drdata    = drd_r;
   assign per_req   = (dst_r == D_PER);
   assign per_we    = per_we_r;
   assign per_addr  = per_addr_r;
   assign per_wdata = per_wdata_r;
endmodule // mbxc_memsys

// ### mbxc_memsys_monitor.sv
// Port checker for the memory map and execute-in-place cache
`timescale 1ns/1ps
module mbxc_memsys_monitor (
   input wire logic                  ref_clk,
   input wire logic                  rst,
   input wire logic                  cache_on,
   input wire logic                  ireq,
   input wire logic [23:0]           iaddr,
   input wire logic                  iready,
   input wire logic                  ivalid,
   input wire logic                  ierr,
   input wire logic                  dreq,
   input wire logic [23:0]           daddr,
   input wire logic                  dready,
   input wire logic                  dvalid,
   input wire logic                  derr,
   input wire logic                  per_req,
   input wire logic [19:0]           per_addr,
   input wire logic                  per_ack,
   input wire logic                  raw_grant,
   input wire mbxc_pkg::mbxc_flash_s flash_out,
   input wire logic                  flash_ack
);
   logic dtk;
   logic itk;
   logic fill;
   assign dtk = dreq && dready;
   assign itk = ireq && iready;
   assign fill = flash_out.req && !raw_grant;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   AST_RAW_BLOCK: assert property (cache_on |-> !raw_grant)
      else $error("raw flash granted while caching");
   AST_FILL_READ: assert property (fill |->
      flash_out.cmd == mbxc_pkg::FL_READ && !iready)
      else $error("fill not a plain read or fetch open");
   AST_FILL_STEP: assert property (fill && flash_ack &&
      flash_out.addr[5:2] != mbxc_pkg::LAST_BEAT |=> fill &&
      flash_out.addr[5:2] == $past(flash_out.addr[5:2]) + 4'h1)
      else $error("fill beat order broken");
   AST_FILL_END: assert property (fill && flash_ack &&
      flash_out.addr[5:2] == mbxc_pkg::LAST_BEAT |=> ivalid && !fill)
      else $error("no fetch answer after line fill");
   AST_ROM: assert property (itk && iaddr < 24'h024000 |=>
      ivalid && !ierr) else $error("ROM fetch not answered");
   AST_WIN_OFF: assert property (itk && !cache_on &&
      iaddr >= mbxc_pkg::FLASH_BASE && iaddr < 24'hC00000 |=> ierr)
      else $error("flash fetch taken with cache off");
   AST_DATA_ANS: assert property (dtk &&
      daddr[23:20] != mbxc_pkg::REG_PERIPH |=> dvalid != derr)
      else $error("data access not answered next cycle");
   AST_PER: assert property (dtk && daddr[23:20] == mbxc_pkg::REG_PERIPH
      |=> per_req && per_addr == $past(daddr[19:0]))
      else $error("peripheral access not issued");
   AST_PER_END: assert property (per_req && per_ack |=>
      dvalid && !per_req) else $error("peripheral answer lost");
   AST_BANK6: assert property (dtk && cache_on && daddr >= 24'h134000 &&
      daddr < 24'h13C000 |=> derr)
      else $error("cache bank reachable as data");
   AST_UNMAP: assert property (dtk && daddr[23:20] == 4'h3 |=> derr)
      else $error("unmapped region accepted");
endmodule // mbxc_memsys_monitor

bind mbxc_memsys mbxc_memsys_monitor u_mon (.ref_clk, .rst, .cache_on,
   .ireq, .iaddr, .iready, .ivalid, .ierr, .dreq, .daddr, .dready,
   .dvalid, .derr, .per_req, .per_addr, .per_ack, .raw_grant,
   .flash_out, .flash_ack);

// ### mbxc_pkg.sv
// Constants, types and carriers for the bank map and execute-in-place cache
package mbxc_pkg;
   // Sixteen 1 MB regions over a 16 MB space, region index = addr[23:20]
   localparam int          ADDR_W        = 24;
   localparam int          REGION_COUNT  = 16;
   localparam logic [3:0]  REG_INSTR     = 4'h0;
   localparam logic [3:0]  REG_DATA      = 4'h1;
   localparam logic [3:0]  REG_TAGDIR    = 4'h2;
   localparam logic [3:0]  REG_FLASH_LO  = 4'h4;
   localparam logic [3:0]  REG_FLASH_HI  = 4'hB;
   localparam logic [3:0]  REG_PERIPH    = 4'hF;
   localparam logic [23:0] FLASH_BASE    = 24'h400000;
   // Byte offsets inside the instruction and data regions
   localparam logic [19:0] ROM_BYTES     = 20'h24000;
   localparam logic [19:0] FIX_BYTES     = 20'h04000;
   localparam logic [19:0] IBANK_BASE    = 20'h28000;
   localparam logic [19:0] DBANK_BASE    = 20'h04000;
   localparam int          NBANKS        = 7;
   // Word indices into the shared RAM array
   localparam int          MEM_WORDS     = 65536;
   localparam logic [15:0] WIX_FIX_I     = 16'h0000;
   localparam logic [15:0] WIX_FIX_D     = 16'h1000;
   localparam logic [15:0] WIX_BANK0     = 16'h2000;
   localparam logic [15:0] WIX_CACHE     = 16'hE000;
   // Cache geometry: 2 ways, 64 byte lines, 256 sets, 9 bit tags
   localparam int          LINE_WORDS    = 16;
   localparam int          SETS          = 256;
   localparam int          WAYS          = 2;
   localparam int          TAG_W         = 9;
   localparam int          TD_VALID_BIT  = 31;
   localparam logic [3:0]  LAST_BEAT     = 4'hF;

   typedef enum logic [1:0] {
      BANK_OFF, BANK_INSTR, BANK_DATA, BANK_CACHE
   } mbxc_bank_e;

   typedef enum logic [1:0] {
      FL_READ, FL_WRITE, FL_ERASE
   } mbxc_fcmd_e;

   typedef struct packed {
      logic        req;
      mbxc_fcmd_e  cmd;
      logic [22:0] addr;
      logic [31:0] wdata;
   } mbxc_flash_s;
endpackage

// ### testbench.sv
// Self-checking bench for the bank map and execute-in-place cache
`timescale 1ns/1ps
module testbench;
   logic ref_clk, rst, boot_source_strap, fw_cache_en, cache_on, slow;
   logic ireq, iready, ivalid, ierr, dreq, dwe, dready, dvalid, derr;
   logic per_req, per_we, per_ack, raw_grant, raw_done, flash_ack;
   logic [6:0][1:0]       bank_state;
   logic [23:0]           iaddr, daddr;
   logic [31:0]           irdata, rom_rdata, dwdata, drdata, per_wdata;
   logic [31:0]           per_rdata, raw_rdata, flash_rdata, wd;
   logic [15:0]           rom_addr;
   logic [19:0]           per_addr;
   logic [3:0]            dbe;
   logic [7:0]            s;
   logic [22:0]           off;
   logic [33:0]           n, fq[$], dq[$];
   mbxc_pkg::mbxc_flash_s raw_flash, flash_out;
   int                    errors, cmp_count, beats, seed, i, k, b0;
   localparam logic [33:0] ERR = {2'b10, 32'h0};
   localparam logic [33:0] DONE = 34'h0;
   localparam logic [27:0] TAGS = 28'h1121312;

   mbxc_memsys u_mbxc_memsys (.ref_clk, .rst, .boot_source_strap,
      .fw_cache_en, .bank_state, .cache_on, .ireq, .iaddr, .iready,
      .ivalid, .ierr, .irdata, .rom_addr, .rom_rdata, .dreq, .dwe, .dbe,
      .daddr, .dwdata, .dready, .dvalid, .derr, .drdata, .per_req,
      .per_we, .per_addr, .per_wdata, .per_ack, .per_rdata, .raw_flash,
      .raw_grant, .raw_done, .raw_rdata, .flash_out, .flash_ack,
      .flash_rdata);
   mbxc_flash_model u_mbxc_flash_model (.ref_clk, .flash_out, .slow,
      .flash_ack, .flash_rdata);

   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   // Sync ROM macro, one-cycle peripheral, beat counter
   always @(posedge ref_clk) begin
      rom_rdata <= {~rom_addr, rom_addr};
      per_ack <= per_req && !per_ack;
      // Stores echo their data so per_we and per_wdata are checked
      if (per_req && !per_ack)
         per_rdata <= per_we ? per_wdata : {12'h0, per_addr};
      else
         per_rdata <= ~per_rdata;
      if (flash_ack) beats <= beats + 1;
   end
   function automatic logic [33:0] ok(input logic [31:0] d);
      return {2'b01, d};
   endfunction
   function automatic logic [31:0] fw(input logic [22:0] a);
      return {a, 9'h0A5};
   endfunction
   function automatic logic [31:0] romw(input logic [23:0] a);
      return {~a[17:2], a[17:2]};
   endfunction
   task cmp(input string nm, input logic [33:0] e, input logic [33:0] g);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task end_sim;
      $display("errors=%0d comparisons=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task hang(input string nm);
      errors++;
      $display("[FAIL] %s expected done seen timeout", nm);
      end_sim();
   endtask
   // Watcher: each answer consumes the oldest note
   always @(posedge ref_clk) begin
      if (ivalid || ierr) begin
         n = fq.size() ? fq.pop_front() : '1;
         cmp("fetch", n, {ierr, n[32], n[32] ? irdata : 32'h0});
      end
      if (dvalid || derr) begin
         n = dq.size() ? dq.pop_front() : '1;
         cmp("data", n, {derr, n[32], n[32] ? drdata : 32'h0});
      end
   end
   task fetch(input logic [23:0] a, input logic [33:0] e);
      fq.push_back(e);
      ireq <= 1'b1;
      iaddr <= a;
      for (k = 0; k < 99; k++) begin
         @(posedge ref_clk);
         if (iready) break;
      end
      if (k == 99) hang("fetch");
      ireq <= 1'b0;
      @(posedge ref_clk);
   endtask
   task dacc(input logic w, input logic [3:0] be, input logic [23:0] a,
             input logic [31:0] d, input logic [33:0] e);
      dq.push_back(e);
      {dreq, dwe, dbe, daddr, dwdata} <= {1'b1, w, be, a, d};
      for (k = 0; k < 99; k++) begin
         @(posedge ref_clk);
         if (dready) break;
      end
      if (k == 99) hang("data");
      dreq <= 1'b0;
      @(posedge ref_clk);
   endtask
   task raw(input mbxc_pkg::mbxc_fcmd_e c, input logic [31:0] d,
            input logic [31:0] e);
      raw_flash <= '{1'b1, c, 23'h000100, d};
      for (k = 0; k < 99; k++) begin
         @(posedge ref_clk);
         if (raw_done) break;
      end
      if (k == 99) hang("raw flash");
      if (c == mbxc_pkg::FL_READ) cmp("raw read", e, raw_rdata);
      raw_flash.req <= 1'b0;
      @(posedge ref_clk);
   endtask
   task drain;
      for (k = 0; k < 400 && fq.size() + dq.size() > 0; k++)
         @(posedge ref_clk);
      if (k == 400) hang("answer");
   endtask

   initial begin
      repeat (100000) @(posedge ref_clk);
      hang("run");
   end
   initial begin
      seed = 32'h10383C3D;
      {rst, boot_source_strap, fw_cache_en, slow} = 4'h8;
      {ireq, iaddr, dreq, dwe, dbe, daddr, dwdata} = '0;
      {bank_state, raw_flash, errors, cmp_count, beats} = '0;
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      cmp("cache_on", 34'h1, cache_on);
      for (i = 0; i < 512; i++)
         dacc(1'b1, 4'hF, 24'h200000 + 24'(i * 4), 32'h0, DONE);
      dacc(1'b0, 4'hF, 24'h2007FC, 32'h0, ok(32'h0));
      fetch(24'h000100, ok(romw(24'h000100)));
      fetch(24'h023FFC, ok(romw(24'h023FFC)));
      fetch(24'h024000, DONE);
      fetch(24'h028000, ERR);
      wd = $random(seed);
      dacc(1'b1, 4'hF, 24'h103FFC, wd, DONE);
      dacc(1'b1, 4'h2, 24'h103FFC, 32'h0000A500, DONE);
      dacc(1'b0, 4'hF, 24'h103FFC, 32'h0,
           ok({wd[31:16], 8'hA5, wd[7:0]}));
      // Bank 1 through off, instruction, data and cache states
      for (i = 0; i < 4; i++) begin
         bank_state[1] <= 2'(i);
         fetch(24'h030000, (i == 1) ? DONE : ERR);
         dacc(1'b1, 4'hF, 24'h10C000, wd, (i == 2) ? DONE : ERR);
         dacc(1'b0, 4'hF, 24'h10C000, 32'h0,
              (i == 2) ? ok(wd) : ERR);
      end
      bank_state[6] <= 2'h2;
      dacc(1'b0, 4'hF, 24'h134000, 32'h0, ERR);
      dacc(1'b0, 4'hF, 24'h300000, 32'h0, ERR);
      dacc(1'b0, 4'hF, 24'h000100, 32'h0, ERR);
      dacc(1'b0, 4'hF, 24'hF00010, 32'h0, ok(32'h10));
      dacc(1'b1, 4'hF, 24'hF00020, wd, ok(wd));
      // Same set, three tags: odd steps must hit without flash traffic
      s = $random(seed);
      for (i = 0; i < 7; i++) begin
         slow <= (i > 3);
         b0 = beats;
         off = {9'(TAGS >> (4 * (6 - i)) & 28'hF), s, 4'(i * 3), 2'h0};
         fetch(mbxc_pkg::FLASH_BASE + 24'(off), ok(fw(off)));
         drain();
         cmp("fill beats", (i % 2) ? 0 : 16, beats - b0);
      end
      fetch(24'hBFFFFC, ok(fw(23'h7FFFFC)));
      fetch(24'hC00000, ERR);
      drain();
      raw_flash <= '{1'b1, mbxc_pkg::FL_READ, 23'h0, 32'h0};
      repeat (3) @(posedge ref_clk);
      cmp("raw grant", 34'h0, raw_grant);
      raw_flash.req <= 1'b0;
      rst <= 1'b1;
      boot_source_strap <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      cmp("cache_on", 34'h0, cache_on);
      fetch(24'h400000, ERR);
      dacc(1'b1, 4'hF, 24'h134000, wd, DONE);
      dacc(1'b0, 4'hF, 24'h134000, 32'h0, ok(wd));
      raw(mbxc_pkg::FL_WRITE, ~wd, 32'h0);
      raw(mbxc_pkg::FL_READ, 32'h0, ~wd);
      raw(mbxc_pkg::FL_ERASE, 32'h0, 32'h0);
      raw(mbxc_pkg::FL_READ, 32'h0, 32'hFFFFFFFF);
      fw_cache_en <= 1'b1;
      repeat (2) @(posedge ref_clk);
      cmp("cache_on", 34'h1, cache_on);
      drain();
      end_sim();
   end
endmodule // testbench
